/* File: engine_cfg_pkg.sv */
package engine_cfg_pkg;

  // serial frame layout
  localparam int FRAME_BITS    = 16;
  localparam int ADDR_MSB      = 14;
  localparam int ADDR_LSB      = 10;
  localparam int DATA_MSB      = 8;
  localparam int DATA_LSB      = 1;
  localparam int CMD_LOCK_BIT  = 1;
  localparam int CMD_SWRST_BIT = 2;

  localparam logic [4:0] ADDR_SENSOR_RELAY  = 5'h01;
  localparam logic [4:0] ADDR_PUMP_IGNITION = 5'h02;
  localparam logic [4:0] ADDR_SENSOR_FILTER = 5'h03;
  localparam logic [4:0] ADDR_LATCH_LOCK    = 5'h04;
  localparam logic [4:0] ADDR_SENSOR_HYST   = 5'h05;
  localparam logic [4:0] ADDR_POWER_SAFETY  = 5'h06;
  localparam logic [4:0] ADDR_OUTPUT_DIAG   = 5'h07;
  localparam logic [4:0] ADDR_LOCK_COMMAND  = 5'h0C;

  localparam int CFG_FIRST = 1;
  localparam int CFG_LAST  = 7;

  typedef logic [7:0] cfg_byte_t;
  typedef cfg_byte_t cfg_table_t [CFG_FIRST:CFG_LAST];

  localparam cfg_table_t CFG_RESET = '{8'h08, 8'h08, 8'h08, 8'h02, 8'hD8, 8'h22, 8'h50};
  // writable bits; lock bit of register 4 changes only by command
  localparam cfg_table_t CFG_WMASK = '{8'h03, 8'h03, 8'h03, 8'hF2, 8'h3F, 8'hFF, 8'hFF};

  // field positions
  localparam int RELAY_OT_KEEP_BIT   = 0;
  localparam int ADAPTIVE_SEL_BIT    = 1;
  localparam int LOWSIDE_OFF_BIT     = 0;
  localparam int PUMP_OFF_BIT        = 1;
  localparam int HYST_FB_BIT         = 0;
  localparam int FALL_FILT_BIT       = 1;
  localparam int LOCK_BIT            = 0;
  localparam int KLINE_SLEW_BIT      = 1;
  localparam int LC_DIAG_BIT         = 4;
  localparam int TIMEOUT_MSB         = 7;
  localparam int TIMEOUT_LSB         = 5;
  localparam int HYST_CODE_MSB       = 2;
  localparam int HYST_CODE_LSB       = 0;
  localparam int AUTO_HYST_BIT       = 3;
  localparam int AUTO_FILT_BIT       = 4;
  localparam int SENSOR_DIAG_BIT     = 5;
  localparam int PRIO_SEL_BIT        = 0;
  localparam int WD_BASE_BIT         = 1;
  localparam int UV_WDA_MASK_BIT     = 2;
  localparam int UV_RST_MASK_BIT     = 3;
  localparam int SUPPLY_SHUTDOWN_SELECT_BIT           = 4;
  localparam int HOLD_EN_LOW_BIT     = 5;
  localparam int KEY_RESET_BIT       = 6;
  localparam int CAN_ERR_BIT         = 7;
  localparam int LB_OUT13_BIT        = 0;
  localparam int LB_OUT14_BIT        = 1;
  localparam int LB_STAGE_A_BIT      = 2;
  localparam int LB_STAGE_C_BIT      = 3;
  localparam int STEPPER_BIT         = 4;
  localparam int MASK_DOUBLE_BIT     = 5;
  localparam int IGN_GND_DIAG_BIT    = 6;
  localparam int IGN_LATCH_BIT       = 7;

  localparam logic [2:0] TIMEOUT_OFF = 3'h0;

  // hysteresis current in microamps per code
  localparam logic [5:0] HYST_UA_0  = 6'h00;
  localparam logic [5:0] HYST_UA_5  = 6'h05;
  localparam logic [5:0] HYST_UA_10 = 6'h0A;
  localparam logic [5:0] HYST_UA_17 = 6'h11;
  localparam logic [5:0] HYST_UA_32 = 6'h20;
  localparam logic [5:0] HYST_UA_51 = 6'h33;

  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_t;

endpackage

/* File: engine_ic_config_regs.sv */
// How it works
// - bit1 reg1 selects limited or full adaptive
// - bit0 reg1 keeps relay on at overtemperature
// - reg2 pump off and ignition lowside forced off
// - reg3 falling filter enable, hysteresis feedback point
// - reg4 7:5 latch timeout code, 000 off
// - reg4 bit4 low-current offstate diag and bias
// - reg4 bit1 enables kline slew limit
// - lock bit set/cleared by command, blocks writes
// - reg5 bit5 diag or forced minimum hysteresis
// - reg5 4:3 independent auto filter and hysteresis
// - reg5 2:0 decodes hysteresis current
// - reg6 bit7 enables CAN error handling
// - reg6 bit6 key rise in latch resets
// - reg6 bit5 active-low power latch enable
// - reg6 bit4 chooses supply shutdown at key off
// - reg6 3:2 mask undervoltage reset and alarm
// - reg6 bit1 selects watchdog time base
// - reg6 bit0 picks winning timeout counter
// - reg7 ignition latch mode, ground diag enable
// - reg7 mask time double, stepper select
// - reg7 3:0 low-battery enables, bridge override
// - reset unlocked; software reset reloads all registers with their reset values
module engine_ic_config_regs
  import engine_cfg_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic       key_on,
  input  wire logic       power_hold_mode,
  input  wire logic       relay_overtemp,
  input  wire logic       main_supply_undervoltage,
  output logic            config_locked,
  output logic            frame_error,
  output logic            software_reset,
  output logic            sensor_adaptive_select,
  output logic            relay_overtemp_keep_on,
  output logic            main_relay_driver_ot_off,
  output logic            charge_pump_off,
  output logic            ignition_lowside_force_off,
  output logic            falling_edge_filter_enable,
  output logic            hysteresis_feedback_select,
  output logic [2:0]      latch_timeout_select,
  output logic            latch_timeout_enable,
  output logic            low_current_offstate_diag,
  output logic            kline_slew_limit,
  output logic            sensor_diag_enable,
  output logic            sensor_min_hyst_force,
  output logic            auto_hysteresis_enable,
  output logic            auto_filter_enable,
  output logic [2:0]      sensor_hysteresis_code,
  output logic [5:0]      hysteresis_current_ua,
  output logic            can_error_enable,
  output logic            key_on_latch_reset,
  output logic            power_hold_enable_low,
  output logic            supply_shutdown,
  output logic            uv_reset_request,
  output logic            watchdog_alarm_pin_low,
  output logic            watchdog_response_time,
  output logic            secure_off_priority,
  output logic            ignition_diag_latch_mode,
  output logic            ignition_ground_diag_enable,
  output logic            mask_time_double,
  output logic            stepper_mode,
  output logic [3:0]      lowbatt_enable,
  output logic            bridge_override
);

  cfg_table_t            cfg;
  link_state_t           link_state;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [4:0]            bit_count;
  logic                  sclk_q;
  logic                  key_q;
  logic                  frame_done;
  logic                  frame_ok;
  logic [4:0]            frame_addr;
  logic [7:0]            frame_data;
  logic                  sclk_rise;
  logic                  sclk_fall;

  assign sclk_rise  = sclk & ~sclk_q;
  assign sclk_fall  = ~sclk & sclk_q;
  assign frame_addr = shift_in[ADDR_MSB:ADDR_LSB];
  assign frame_data = shift_in[DATA_MSB:DATA_LSB];
  // frame ends on deselect; only exact 16-bit frames with odd parity count
  assign frame_done = (link_state == LINK_FRAME) && cs_n;
  assign frame_ok   = frame_done && (bit_count == 5'(FRAME_BITS)) && (^shift_in);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      key_q  <= 1'b0;
    end else begin
      sclk_q <= sclk;
      key_q  <= key_on;
    end
  end

  // serial link: sample on rising clock, shift reply on falling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_state <= LINK_IDLE;
      shift_in   <= '0;
      shift_out  <= '0;
      bit_count  <= '0;
      miso       <= 1'b0;
    end else begin
      case (link_state)
        LINK_IDLE: begin
          if (!cs_n) begin
            link_state <= LINK_FRAME;
            bit_count  <= '0;
            // reply: previous error, then lock status
            shift_out  <= {frame_error, 13'h0000, config_locked, ~(frame_error ^ config_locked)};
            miso       <= frame_error;
          end
        end
        LINK_FRAME: begin
          if (cs_n) begin
            link_state <= LINK_IDLE;
          end else begin
            if (sclk_rise) begin
              shift_in <= {shift_in[FRAME_BITS-2:0], mosi};
              if (bit_count != 5'h1F) begin
                bit_count <= bit_count + 5'h01;
              end
            end
            if (sclk_fall) begin
              shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
              miso      <= shift_out[FRAME_BITS-2];
            end
          end
        end
        default: link_state <= LINK_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_error <= 1'b0;
    end else if (frame_done) begin
      frame_error <= ~frame_ok;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      software_reset <= 1'b0;
    end else begin
      software_reset <= frame_ok && (frame_addr == ADDR_LOCK_COMMAND) && shift_in[CMD_SWRST_BIT];
    end
  end

  // configuration table
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (frame_ok) begin
      if (frame_addr == ADDR_LOCK_COMMAND) begin
        if (shift_in[CMD_SWRST_BIT]) begin
          cfg <= CFG_RESET;
        end else begin
          cfg[ADDR_LATCH_LOCK][LOCK_BIT] <= shift_in[CMD_LOCK_BIT];
        end
      end else if (!cfg[ADDR_LATCH_LOCK][LOCK_BIT]) begin
        for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
          if (frame_addr == 5'(i)) begin
            cfg[i] <= (frame_data & CFG_WMASK[i]) | (cfg[i] & ~CFG_WMASK[i]);
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_on_latch_reset <= 1'b0;
    end else begin
      key_on_latch_reset <= cfg[ADDR_POWER_SAFETY][KEY_RESET_BIT] && power_hold_mode
                            && key_on && !key_q;
    end
  end

  always_comb begin
    case (cfg[ADDR_SENSOR_HYST][HYST_CODE_MSB:HYST_CODE_LSB])
      3'h1:    hysteresis_current_ua = HYST_UA_5;
      3'h2:    hysteresis_current_ua = HYST_UA_10;
      3'h4:    hysteresis_current_ua = HYST_UA_32;
      3'h5:    hysteresis_current_ua = HYST_UA_51;
      3'h7:    hysteresis_current_ua = HYST_UA_0;
      default: hysteresis_current_ua = HYST_UA_17;
    endcase
  end

  assign config_locked              = cfg[ADDR_LATCH_LOCK][LOCK_BIT];
  assign sensor_adaptive_select     = cfg[ADDR_SENSOR_RELAY][ADAPTIVE_SEL_BIT];
  assign relay_overtemp_keep_on     = cfg[ADDR_SENSOR_RELAY][RELAY_OT_KEEP_BIT];
  assign main_relay_driver_ot_off   = relay_overtemp & ~relay_overtemp_keep_on;
  assign charge_pump_off            = cfg[ADDR_PUMP_IGNITION][PUMP_OFF_BIT];
  assign ignition_lowside_force_off = cfg[ADDR_PUMP_IGNITION][LOWSIDE_OFF_BIT];
  assign falling_edge_filter_enable = cfg[ADDR_SENSOR_FILTER][FALL_FILT_BIT];
  assign hysteresis_feedback_select = cfg[ADDR_SENSOR_FILTER][HYST_FB_BIT];
  assign latch_timeout_select       = cfg[ADDR_LATCH_LOCK][TIMEOUT_MSB:TIMEOUT_LSB];
  assign latch_timeout_enable       = latch_timeout_select != TIMEOUT_OFF;
  assign low_current_offstate_diag  = cfg[ADDR_LATCH_LOCK][LC_DIAG_BIT];
  assign kline_slew_limit           = cfg[ADDR_LATCH_LOCK][KLINE_SLEW_BIT];
  // one bit, two meanings depending on adaptive mode
  assign sensor_diag_enable    = sensor_adaptive_select & cfg[ADDR_SENSOR_HYST][SENSOR_DIAG_BIT];
  assign sensor_min_hyst_force = ~sensor_adaptive_select & cfg[ADDR_SENSOR_HYST][SENSOR_DIAG_BIT];
  assign auto_hysteresis_enable     = cfg[ADDR_SENSOR_HYST][AUTO_HYST_BIT];
  assign auto_filter_enable         = cfg[ADDR_SENSOR_HYST][AUTO_FILT_BIT];
  assign sensor_hysteresis_code     = cfg[ADDR_SENSOR_HYST][HYST_CODE_MSB:HYST_CODE_LSB];
  assign can_error_enable           = cfg[ADDR_POWER_SAFETY][CAN_ERR_BIT];
  assign power_hold_enable_low      = cfg[ADDR_POWER_SAFETY][HOLD_EN_LOW_BIT];
  assign supply_shutdown            = ~key_on & ~power_hold_enable_low
                                      & ~cfg[ADDR_POWER_SAFETY][SUPPLY_SHUTDOWN_SELECT_BIT];
  assign uv_reset_request           = main_supply_undervoltage
                                      & ~cfg[ADDR_POWER_SAFETY][UV_RST_MASK_BIT];
  assign watchdog_alarm_pin_low     = main_supply_undervoltage
                                      & ~cfg[ADDR_POWER_SAFETY][UV_WDA_MASK_BIT];
  assign watchdog_response_time     = cfg[ADDR_POWER_SAFETY][WD_BASE_BIT];
  assign secure_off_priority        = cfg[ADDR_POWER_SAFETY][PRIO_SEL_BIT];
  assign ignition_diag_latch_mode   = cfg[ADDR_OUTPUT_DIAG][IGN_LATCH_BIT];
  assign ignition_ground_diag_enable = cfg[ADDR_OUTPUT_DIAG][IGN_GND_DIAG_BIT];
  assign mask_time_double           = cfg[ADDR_OUTPUT_DIAG][MASK_DOUBLE_BIT];
  assign stepper_mode               = cfg[ADDR_OUTPUT_DIAG][STEPPER_BIT];
  assign lowbatt_enable             = cfg[ADDR_OUTPUT_DIAG][LB_STAGE_C_BIT:LB_OUT13_BIT];
  assign bridge_override            = cfg[ADDR_OUTPUT_DIAG][LB_STAGE_A_BIT]
                                      | cfg[ADDR_OUTPUT_DIAG][LB_STAGE_C_BIT];

endmodule

/* File: engine_ic_config_regs_assertions.sv */
module engine_cfg_checker
  import engine_cfg_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       key_on,
  input wire logic       power_hold_mode,
  input wire logic       relay_overtemp,
  input wire logic       main_supply_undervoltage,
  input wire logic       config_locked,
  input wire logic       software_reset,
  input wire logic       sensor_adaptive_select,
  input wire logic       relay_overtemp_keep_on,
  input wire logic       main_relay_driver_ot_off,
  input wire logic [2:0] latch_timeout_select,
  input wire logic       latch_timeout_enable,
  input wire logic       sensor_diag_enable,
  input wire logic       sensor_min_hyst_force,
  input wire logic [2:0] sensor_hysteresis_code,
  input wire logic [5:0] hysteresis_current_ua,
  input wire logic       key_on_latch_reset,
  input wire logic       power_hold_enable_low,
  input wire logic       supply_shutdown,
  input wire logic       uv_reset_request,
  input wire logic       watchdog_alarm_pin_low,
  input wire logic [3:0] lowbatt_enable,
  input wire logic       bridge_override
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // lock may only move one cycle after a frame closes
  sequence frame_closed;
    $past(cs_n) && !$past(cs_n, 2);
  endsequence
  sequence single_pulse(s);
    s ##1 !s;
  endsequence
  relay_ot_a: assert property (main_relay_driver_ot_off == (relay_overtemp && !relay_overtemp_keep_on))
    else $error("relay overtemp switch-off wrong");
  timeout_en_a: assert property (latch_timeout_enable == (latch_timeout_select != 3'h0))
    else $error("latch timeout enable wrong");
  diag_split_a: assert property (!(sensor_diag_enable && !sensor_adaptive_select)
    && !(sensor_min_hyst_force && sensor_adaptive_select)) else $error("sensor diag or min hysteresis wrong");
  uv_mask_a: assert property (!main_supply_undervoltage |-> !uv_reset_request && !watchdog_alarm_pin_low)
    else $error("undervoltage reaction without cause");
  supply_hold_a: assert property (key_on || power_hold_enable_low |-> !supply_shutdown)
    else $error("supply shut down with key on or latch off");
  bridge_ovr_a: assert property (bridge_override == (lowbatt_enable[2] || lowbatt_enable[3]))
    else $error("bridge override wrong");
  test_hyst_a: assert property (sensor_hysteresis_code == 3'h7 |-> hysteresis_current_ua == HYST_UA_0)
    else $error("test hysteresis not zero");
  lock_move_a: assert property ($changed(config_locked) |-> frame_closed)
    else $error("lock changed outside frame end");
  swrst_clear_a: assert property (software_reset |-> !config_locked ##0 single_pulse(software_reset))
    else $error("software reset left lock or stretched");
  key_reset_a: assert property (key_on_latch_reset |-> $past(key_on) && !$past(key_on, 2)
    && $past(power_hold_mode) ##0 single_pulse(key_on_latch_reset)) else $error("key reset out of power latch");
endmodule
bind engine_ic_config_regs engine_cfg_checker i_chk (.mclk, .rst_n, .cs_n, .key_on, .power_hold_mode, .relay_overtemp,
  .main_supply_undervoltage, .config_locked, .software_reset, .sensor_adaptive_select, .relay_overtemp_keep_on,
  .main_relay_driver_ot_off, .latch_timeout_select, .latch_timeout_enable, .sensor_diag_enable, .sensor_min_hyst_force,
  .sensor_hysteresis_code, .hysteresis_current_ua, .key_on_latch_reset, .power_hold_enable_low, .supply_shutdown,
  .uv_reset_request, .watchdog_alarm_pin_low, .lowbatt_enable, .bridge_override);

/* File: engine_ic_config_regs_bench.sv */
module engine_ic_config_regs_bench
  import engine_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, cs_n, sclk, mosi, miso, key_on, power_hold_mode, relay_overtemp, main_supply_undervoltage;
  logic config_locked, frame_error, software_reset, sensor_adaptive_select, relay_overtemp_keep_on;
  logic main_relay_driver_ot_off, charge_pump_off, ignition_lowside_force_off, falling_edge_filter_enable;
  logic hysteresis_feedback_select, latch_timeout_enable, low_current_offstate_diag, kline_slew_limit;
  logic sensor_diag_enable, sensor_min_hyst_force, auto_hysteresis_enable, auto_filter_enable, can_error_enable;
  logic key_on_latch_reset, power_hold_enable_low, supply_shutdown, uv_reset_request, watchdog_alarm_pin_low;
  logic watchdog_response_time, secure_off_priority, ignition_diag_latch_mode, ignition_ground_diag_enable;
  logic mask_time_double, stepper_mode, bridge_override, lk;
  logic [2:0] latch_timeout_select, sensor_hysteresis_code;
  logic [5:0] hysteresis_current_ua;
  logic [3:0] lowbatt_enable;
  logic [15:0] host_rx;
  cfg_table_t ex;
  int         error_cnt, n_tests, swp, klp, k0;
  logic [7:0] pat [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};

  spi_host_model i_host (.mclk, .miso, .cs_n, .sclk, .mosi, .rx(host_rx));
  engine_ic_config_regs i_dut (.mclk, .rst_n, .cs_n, .sclk, .mosi, .miso, .key_on, .power_hold_mode, .relay_overtemp,
    .main_supply_undervoltage, .config_locked, .frame_error, .software_reset, .sensor_adaptive_select,
    .relay_overtemp_keep_on, .main_relay_driver_ot_off, .charge_pump_off, .ignition_lowside_force_off,
    .falling_edge_filter_enable, .hysteresis_feedback_select, .latch_timeout_select, .latch_timeout_enable,
    .low_current_offstate_diag, .kline_slew_limit, .sensor_diag_enable, .sensor_min_hyst_force,
    .auto_hysteresis_enable, .auto_filter_enable, .sensor_hysteresis_code, .hysteresis_current_ua, .can_error_enable,
    .key_on_latch_reset, .power_hold_enable_low, .supply_shutdown, .uv_reset_request, .watchdog_alarm_pin_low,
    .watchdog_response_time, .secure_off_priority, .ignition_diag_latch_mode, .ignition_ground_diag_enable,
    .mask_time_double, .stepper_mode, .lowbatt_enable, .bridge_override);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (software_reset === 1'b1) swp++;
    if (key_on_latch_reset === 1'b1) klp++;
  end

  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask
  function automatic logic [5:0] ua(input logic [2:0] c);
    case (c)
      3'h1: return HYST_UA_5;
      3'h2: return HYST_UA_10;
      3'h4: return HYST_UA_32;
      3'h5: return HYST_UA_51;
      3'h7: return HYST_UA_0;
      default: return HYST_UA_17;
    endcase
  endfunction
  task automatic chk_cfg(input string m);
    logic [42:0] e;
    logic [42:0] o;
    e = {ex[1][1:0], relay_overtemp & ~ex[1][0], ex[2][1:0], ex[3][1:0], ex[4][7:5], |ex[4][7:5], ex[4][4], ex[4][1],
         lk, ex[1][1] & ex[5][5], ~ex[1][1] & ex[5][5], ex[5][3], ex[5][4], ex[5][2:0], ua(ex[5][2:0]), ex[6][7],
         ex[6][5], ~key_on & ~ex[6][5] & ~ex[6][4], main_supply_undervoltage & ~ex[6][3],
         main_supply_undervoltage & ~ex[6][2], ex[6][1:0], ex[7], ex[7][2] | ex[7][3]};
    o = {sensor_adaptive_select, relay_overtemp_keep_on, main_relay_driver_ot_off, charge_pump_off,
         ignition_lowside_force_off, falling_edge_filter_enable, hysteresis_feedback_select, latch_timeout_select,
         latch_timeout_enable, low_current_offstate_diag, kline_slew_limit, config_locked, sensor_diag_enable,
         sensor_min_hyst_force, auto_hysteresis_enable, auto_filter_enable, sensor_hysteresis_code,
         hysteresis_current_ua, can_error_enable, power_hold_enable_low, supply_shutdown, uv_reset_request,
         watchdog_alarm_pin_low, watchdog_response_time, secure_off_priority, ignition_diag_latch_mode,
         ignition_ground_diag_enable, mask_time_double, stepper_mode, lowbatt_enable, bridge_override};
    n_tests++;
    if (o !== e) fail(m);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {1'b0, a, 1'b0, d, 1'b0};
    f[0] = ~^f;
    i_host.xfer(f, FRAME_BITS);
    if (a == ADDR_LOCK_COMMAND && f[CMD_SWRST_BIT]) begin
      ex = CFG_RESET;
      lk = 1'b0;
    end else if (a == ADDR_LOCK_COMMAND) lk = f[CMD_LOCK_BIT];
    else if (!lk && a >= CFG_FIRST && a <= CFG_LAST) ex[a] = (ex[a] & ~CFG_WMASK[a]) | (d & CFG_WMASK[a]);
  endtask

  initial begin
    {rst_n, key_on, power_hold_mode, relay_overtemp, main_supply_undervoltage, lk} = 6'h00;
    {error_cnt, n_tests, swp, klp} = '0;
    ex = CFG_RESET;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk_cfg("reset values");
    for (int p = 0; p < 4; p++)
      for (int a = 1; a <= 7; a++) begin
        // filter time kept on in limited mode
        // inputs set first so the outputs have settled when compared
        {key_on, relay_overtemp, main_supply_undervoltage} = 3'(a + p);
        wr(5'(a), pat[p] | ((a == 5) ? 8'h10 : 8'h00));
        chk_cfg("field decode");
      end
    wr(ADDR_SENSOR_RELAY, 8'h02);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_SENSOR_HYST, 8'({c[1:0], c[2:0]}));
      chk_cfg("hysteresis code");
    end
    wr(ADDR_LOCK_COMMAND, 8'h01);
    wr(ADDR_OUTPUT_DIAG, 8'hAA);
    chk_word(host_rx, 16'h0002, "reply lock status");
    chk_cfg("write while locked");
    wr(ADDR_LOCK_COMMAND, 8'h00);
    i_host.xfer(16'h0402, FRAME_BITS);
    chk_cfg("even parity frame");
    chk_bit(frame_error, 1'b1, "frame error flag");
    i_host.xfer(16'h0406, FRAME_BITS - 1);
    chk_word(host_rx, 16'h8000, "reply error status");
    chk_cfg("short frame");
    chk_bit(frame_error, 1'b1, "short frame flag");
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_POWER_SAFETY, v ? 8'h40 : 8'h00);
      key_on = 1'b0;
      power_hold_mode = 1'b1;
      repeat (3) @(negedge mclk);
      k0 = klp;
      key_on = 1'b1;
      repeat (4) @(negedge mclk);
      chk_bit(klp == k0 + v, 1'b1, "key rise reset");
      power_hold_mode = 1'b0;
    end
    chk_bit(frame_error, 1'b0, "frame error clear");
    wr(ADDR_LOCK_COMMAND, 8'h01);
    k0 = swp;
    wr(ADDR_LOCK_COMMAND, 8'h02);
    chk_bit(swp == k0 + 1, 1'b1, "software reset pulse");
    chk_cfg("after software reset");
    wr(ADDR_LOCK_COMMAND, 8'h01);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    ex = CFG_RESET;
    lk = 1'b0;
    @(negedge mclk);
    chk_cfg("after mid-run reset");
    conclude();
  end
  initial begin
    #1_000_000;
    fail("watchdog expired");
    conclude();
  end
endmodule

/* File: spi_host_model.sv */
module spi_host_model (
  input  wire logic        mclk,
  input  wire logic        miso,
  output logic             cs_n,
  output logic             sclk,
  output logic             mosi,
  output logic      [15:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rx   = '0;
  end
  // top n bits msb first; each sclk level held two mclk so the sampler sees it
  task automatic xfer(input logic [15:0] f, input int n);
    @(negedge mclk);
    cs_n = 1'b0;
    rx   = '0;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = f[i];
      repeat (2) @(negedge mclk);
      // reply bit stands from the previous falling sclk; the first one stands from the select
      rx[i] = miso;
      sclk = 1'b1;
      repeat (2) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge mclk);
    cs_n = 1'b1;
    // released line must not keep the last bit
    mosi = ~mosi;
    repeat (4) @(negedge mclk);
  endtask
endmodule
